// ### include/plc_regs.vh
/*
 * Register map, field positions, reset values and scaling constants
 * of the loop control register bank.
 * Assumes it is included by bare name from the design and verification files.
 */
// Functional notes
// (R1) Pump down current is code in bits 6:0 times 20 uA.
// (R2) Pump up current is code in bits 13:7 times 20 uA.
// (R3) Leakage magnitude is code in bits 20:14 times 5 uA.
// (R4) Host sets leakage down enable bit 22 in fractional mode only; resets to 1.
// (R5) Host keeps leakage up enable bit 21 at 0, its reset value.
// (R6) Calibration window lasts 1,2,4,8,32,64,128,256 divided reference cycles.
// (R7) Force curve bit 10 makes calibration use the held curve value.
// (R8) Suppress bit 12 stops curve register writes from starting a transfer.
// (R9) Calibration clock is reference divided by 1,4,16 or 32.
// (R10) Host programs detector reset delay bits 2:0 to 001.
// (R11) Detector up output passes only while bit 5 is 1.
// (R12) Detector down output passes only while bit 6 is 1.
// (R13) Extra loop current when phase error exceeds 5.4, 14.4 or 24.1 ns.
// (R14) Bit 9 forces pump up output on, for test.
// (R15) Bit 10 forces pump down output on, for test.
// (R16) Reserved bits store and return writes; host writes reset values back.
`ifndef PLC_REGS_VH
`define PLC_REGS_VH

`define PLC_ADDR_W          5
`define PLC_DATA_W          24
`define PLC_ADDR_CURVE      5'h05
`define PLC_ADDR_PUMP       5'h09
`define PLC_ADDR_CAL        5'h0A
`define PLC_ADDR_DET        5'h0B

`define PLC_RST_PUMP        24'h403264
`define PLC_RST_CAL         24'h002205
`define PLC_RST_DET         24'h0F8061

`define PLC_F_PUMP_DN       6:0
`define PLC_F_PUMP_UP       13:7
`define PLC_F_LEAK_MAG      20:14
`define PLC_B_LEAK_UP       21
`define PLC_B_LEAK_DN       22
`define PLC_F_CAL_WIN       2:0
`define PLC_B_FORCE_CURVE   10
`define PLC_B_SKIP_CAL      11
`define PLC_B_SUPPRESS      12
`define PLC_F_CAL_DIV       14:13
`define PLC_F_DET_DELAY     2:0
`define PLC_B_DET_UP_EN     5
`define PLC_B_DET_DN_EN     6
`define PLC_F_SLIP          8:7
`define PLC_B_UP_OVR        9
`define PLC_B_DN_OVR        10

`define PLC_PUMP_STEP_UA    12'h014
`define PLC_LEAK_STEP_UA    10'h005

// Phase error thresholds in tenths of a nanosecond
`define PLC_SLIP_T1         9'h036
`define PLC_SLIP_T2         9'h090
`define PLC_SLIP_T3         9'h0F1

// Terminal counts are ratio minus one
`define PLC_DIV_T0          5'h00
`define PLC_DIV_T1          5'h03
`define PLC_DIV_T2          5'h0F
`define PLC_DIV_T3          5'h1F

`define PLC_WIN_T0          9'h000
`define PLC_WIN_T1          9'h001
`define PLC_WIN_T2          9'h003
`define PLC_WIN_T3          9'h007
`define PLC_WIN_T4          9'h01F
`define PLC_WIN_T5          9'h03F
`define PLC_WIN_T6          9'h07F
`define PLC_WIN_T7          9'h0FF

`endif

// ### src/plc_cal_timebase.v
/*
 * Calibration timebase: divides the reference clock for the calibration
 * sequencer and measures a tuning window of divided cycles.
 * Assumes clock_i is the reference and start_i is a same-clock pulse.
 */
`timescale 1ns/100ps
`default_nettype none
`include "plc_regs.vh"

module plc_cal_timebase (
    input  wire       clock_i,
    input  wire       srst_i,
    input  wire       ce_i,
    input  wire [1:0] div_sel_i,
    input  wire [2:0] win_sel_i,
    input  wire       start_i,
    output reg        tick_o,
    output reg        busy_o,
    output reg        done_o
);
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RUN  = 2'b10;

    reg [1:0] state_q;
    reg [4:0] div_cnt_q;
    reg [8:0] win_cnt_q;
    reg [8:0] win_term_q;
    reg [4:0] div_term;
    reg [8:0] win_term;

    always @* begin
        case (div_sel_i)
            2'h0:    div_term = `PLC_DIV_T0;
            2'h1:    div_term = `PLC_DIV_T1;
            2'h2:    div_term = `PLC_DIV_T2;
            default: div_term = `PLC_DIV_T3;
        endcase
    end

    always @* begin
        case (win_sel_i)
            3'h0:    win_term = `PLC_WIN_T0;
            3'h1:    win_term = `PLC_WIN_T1;
            3'h2:    win_term = `PLC_WIN_T2;
            3'h3:    win_term = `PLC_WIN_T3;
            3'h4:    win_term = `PLC_WIN_T4;
            3'h5:    win_term = `PLC_WIN_T5;
            3'h6:    win_term = `PLC_WIN_T6;
            default: win_term = `PLC_WIN_T7;
        endcase
    end

    // Divider free-runs; a ratio change takes effect at once, as the count is compared with the live ratio
    always @(posedge clock_i) begin
        if (srst_i) begin
            div_cnt_q <= 5'h00;
            tick_o    <= 1'b0;
        end else if (ce_i) begin
            if (div_cnt_q >= div_term) begin // [R9]
                div_cnt_q <= 5'h00;
                tick_o    <= 1'b1;
            end else begin
                div_cnt_q <= div_cnt_q + 5'h01;
                tick_o    <= 1'b0;
            end
        end
    end

    // Window length is latched at start so a rewrite cannot cut it short
    always @(posedge clock_i) begin
        if (srst_i) begin
            state_q    <= ST_IDLE;
            win_cnt_q  <= 9'h000;
            win_term_q <= 9'h000;
            busy_o     <= 1'b0;
            done_o     <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start_i) begin
                        state_q    <= ST_RUN;
                        win_cnt_q  <= 9'h000;
                        win_term_q <= win_term;
                        busy_o     <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (tick_o) begin
                        if (win_cnt_q == win_term_q) begin // [R6]
                            state_q <= ST_IDLE;
                            busy_o  <= 1'b0;
                            done_o  <= 1'b1;
                        end else begin
                            win_cnt_q <= win_cnt_q + 9'h001;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_o  <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### src/plc_loop_regs.v
/*
 * Loop control register bank: pump, calibration and phase detector
 * configuration registers with their decoded outputs.
 * Assumes a serial front end delivering decoded word accesses, and
 * raw detector pulses arriving asynchronously from the analog core.
 */
`timescale 1ns/100ps
`default_nettype none
`include "plc_regs.vh"

module plc_loop_regs (
    input  wire                   clock_i,
    input  wire                   srst_i,
    input  wire                   ce_i,
    input  wire [`PLC_ADDR_W-1:0] reg_addr_i,
    input  wire [`PLC_DATA_W-1:0] reg_wdata_i,
    input  wire                   reg_wr_i,
    input  wire                   reg_rd_i,
    output reg  [`PLC_DATA_W-1:0] reg_rdata_o,
    output reg                    reg_rvalid_o,
    input  wire                   det_up_raw_i,
    input  wire                   det_dn_raw_i,
    input  wire [8:0]             phase_err_i,
    input  wire                   cal_start_i,
    output reg  [11:0]            pump_down_current_o,
    output reg  [11:0]            pump_up_current_o,
    output reg  [9:0]             leak_current_o,
    output reg                    leakage_up_on_o,
    output reg                    leakage_down_on_o,
    output reg  [2:0]             detector_reset_delay_o,
    output reg                    pump_up_o,
    output reg                    pump_down_o,
    output reg                    slip_boost_o,
    output reg                    use_forced_curve_o,
    output reg                    skip_oscillator_cal_o,
    output reg                    cal_transfer_start_o,
    output wire                   cal_tick_o,
    output wire                   cal_busy_o,
    output wire                   cal_done_o
);
    reg [`PLC_DATA_W-1:0] pump_cfg_q;
    reg [`PLC_DATA_W-1:0] cal_cfg_q;
    reg [`PLC_DATA_W-1:0] det_cfg_q;
    reg [2:0]             up_sync_q;
    reg [2:0]             dn_sync_q;
    reg                   up_clean_q;
    reg                   dn_clean_q;

    function [8:0] slip_threshold;
        input [1:0] mode;
        begin
            case (mode)
                2'h1:    slip_threshold = `PLC_SLIP_T1;
                2'h2:    slip_threshold = `PLC_SLIP_T2;
                default: slip_threshold = `PLC_SLIP_T3;
            endcase
        end
    endfunction

    // All bits are stored, reserved ones included, and read back as written
    always @(posedge clock_i) begin
        if (srst_i) begin
            pump_cfg_q <= `PLC_RST_PUMP;
            cal_cfg_q  <= `PLC_RST_CAL;
            det_cfg_q  <= `PLC_RST_DET;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == `PLC_ADDR_PUMP) begin
                pump_cfg_q <= reg_wdata_i; // [R16]
            end else if (reg_addr_i == `PLC_ADDR_CAL) begin
                cal_cfg_q <= reg_wdata_i; // [R16]
            end else if (reg_addr_i == `PLC_ADDR_DET) begin
                det_cfg_q <= reg_wdata_i; // [R16]
            end
        end
    end

    // Unmapped addresses read zero; the curve register lives elsewhere
    always @(posedge clock_i) begin
        if (srst_i) begin
            reg_rdata_o  <= {`PLC_DATA_W{1'b0}};
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (!reg_rd_i) begin
                reg_rdata_o <= reg_rdata_o;
            end else if (reg_addr_i == `PLC_ADDR_PUMP) begin
                reg_rdata_o <= pump_cfg_q;
            end else if (reg_addr_i == `PLC_ADDR_CAL) begin
                reg_rdata_o <= cal_cfg_q;
            end else if (reg_addr_i == `PLC_ADDR_DET) begin
                reg_rdata_o <= det_cfg_q;
            end else begin
                reg_rdata_o <= {`PLC_DATA_W{1'b0}};
            end
        end
    end

    // Three-stage synchronisers; a level is accepted once stages two and
    // three agree, which filters a single-cycle metastable glitch
    always @(posedge clock_i) begin
        if (srst_i) begin
            up_sync_q  <= 3'h0;
            dn_sync_q  <= 3'h0;
            up_clean_q <= 1'b0;
            dn_clean_q <= 1'b0;
        end else if (ce_i) begin
            up_sync_q <= {up_sync_q[1:0], det_up_raw_i};
            dn_sync_q <= {dn_sync_q[1:0], det_dn_raw_i};
            if (up_sync_q[1] == up_sync_q[2]) begin
                up_clean_q <= up_sync_q[2];
            end
            if (dn_sync_q[1] == dn_sync_q[2]) begin
                dn_clean_q <= dn_sync_q[2];
            end
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            pump_down_current_o    <= 12'h000;
            pump_up_current_o      <= 12'h000;
            leak_current_o         <= 10'h000;
            leakage_up_on_o        <= 1'b0;
            leakage_down_on_o      <= 1'b0;
            detector_reset_delay_o <= 3'h0;
            pump_up_o              <= 1'b0;
            pump_down_o            <= 1'b0;
            slip_boost_o           <= 1'b0;
            use_forced_curve_o     <= 1'b0;
            skip_oscillator_cal_o  <= 1'b0;
            cal_transfer_start_o   <= 1'b0;
        end else if (ce_i) begin
            pump_down_current_o <= {5'h00, pump_cfg_q[`PLC_F_PUMP_DN]} * `PLC_PUMP_STEP_UA; // [R1]
            pump_up_current_o   <= {5'h00, pump_cfg_q[`PLC_F_PUMP_UP]} * `PLC_PUMP_STEP_UA; // [R2]
            leak_current_o      <= {3'h0, pump_cfg_q[`PLC_F_LEAK_MAG]} * `PLC_LEAK_STEP_UA; // [R3]
            // Direction bits are passed as programmed; choosing them is software's job
            leakage_up_on_o        <= pump_cfg_q[`PLC_B_LEAK_UP]; // [R5]
            leakage_down_on_o      <= pump_cfg_q[`PLC_B_LEAK_DN]; // [R4]
            detector_reset_delay_o <= det_cfg_q[`PLC_F_DET_DELAY]; // [R10]
            pump_up_o   <= (up_clean_q & det_cfg_q[`PLC_B_DET_UP_EN]) // [R11]
                         | det_cfg_q[`PLC_B_UP_OVR]; // [R14]
            pump_down_o <= (dn_clean_q & det_cfg_q[`PLC_B_DET_DN_EN]) // [R12]
                         | det_cfg_q[`PLC_B_DN_OVR]; // [R15]
            slip_boost_o <= (det_cfg_q[`PLC_F_SLIP] != 2'h0) &&
                            (phase_err_i > slip_threshold(det_cfg_q[`PLC_F_SLIP])); // [R13]
            use_forced_curve_o    <= cal_cfg_q[`PLC_B_FORCE_CURVE]; // [R7]
            skip_oscillator_cal_o <= cal_cfg_q[`PLC_B_SKIP_CAL];
            cal_transfer_start_o  <= reg_wr_i && (reg_addr_i == `PLC_ADDR_CURVE) &&
                                     !cal_cfg_q[`PLC_B_SUPPRESS]; // [R8]
        end
    end

    plc_cal_timebase u_timebase (
        .clock_i   (clock_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .div_sel_i (cal_cfg_q[`PLC_F_CAL_DIV]),
        .win_sel_i (cal_cfg_q[`PLC_F_CAL_WIN]),
        .start_i   (cal_start_i),
        .tick_o    (cal_tick_o),
        .busy_o    (cal_busy_o),
        .done_o    (cal_done_o)
    );
endmodule
`default_nettype wire

// ### verif/plc_loop_regs_chk.sv
/* Port checker for the loop control register bank.
   Assumes it is bound to plc_loop_regs and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
`include "plc_regs.vh"
module plc_loop_regs_chk (
    input wire logic                   clock_i,
    input wire logic                   srst_i,
    input wire logic                   ce_i,
    input wire logic [`PLC_ADDR_W-1:0] reg_addr_i,
    input wire logic [`PLC_DATA_W-1:0] reg_wdata_i,
    input wire logic                   reg_wr_i,
    input wire logic                   reg_rd_i,
    input wire logic                   reg_rvalid_o,
    input wire logic [8:0]             phase_err_i,
    input wire logic                   cal_start_i,
    input wire logic [11:0]            pump_down_current_o,
    input wire logic                   pump_up_o,
    input wire logic                   pump_down_o,
    input wire logic                   slip_boost_o,
    input wire logic                   cal_transfer_start_o,
    input wire logic                   cal_busy_o,
    input wire logic                   cal_done_o
);
    logic [23:0] pump_q;
    logic [23:0] det_q;
    // Shadow copies, since the stored words are not visible at the ports
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pump_q <= `PLC_RST_PUMP;
            det_q  <= `PLC_RST_DET;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == `PLC_ADDR_PUMP) pump_q <= reg_wdata_i;
            if (reg_addr_i == `PLC_ADDR_DET) det_q <= reg_wdata_i;
        end
    end
    function automatic logic [8:0] thr(input logic [1:0] m);
        return m == 2'h1 ? `PLC_SLIP_T1 : m == 2'h2 ? `PLC_SLIP_T2 : `PLC_SLIP_T3;
    endfunction
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    sequence s_rd_taken;
        ce_i && reg_rd_i;
    endsequence
    sequence s_start_idle;
        ce_i && cal_start_i && !cal_busy_o;
    endsequence
    AST_RVALID: assert property (s_rd_taken |=> reg_rvalid_o)
        else $error("read not answered");
    AST_DN_CUR: assert property ($past(ce_i) && !$past(srst_i) |->
        pump_down_current_o == $past(pump_q[6:0]) * 12'h014) else $error("down current");
    AST_UP_GATE: assert property ($past(ce_i) && !$past(srst_i) |->
        ($past(det_q[9]) -> pump_up_o) && (!$past(det_q[5]) && !$past(det_q[9]) -> !pump_up_o))
        else $error("up output gating");
    AST_DN_GATE: assert property ($past(ce_i) && !$past(srst_i) |->
        ($past(det_q[10]) -> pump_down_o) && (!$past(det_q[6]) && !$past(det_q[10]) -> !pump_down_o))
        else $error("down output gating");
    AST_SLIP: assert property ($past(ce_i) && !$past(srst_i) && $stable(phase_err_i) |->
        slip_boost_o == ($past(det_q[8:7]) != 2'h0 && phase_err_i > thr($past(det_q[8:7]))))
        else $error("slip boost wrong");
    AST_XFER: assert property (cal_transfer_start_o |-> $past(reg_wr_i) &&
        $past(reg_addr_i) == `PLC_ADDR_CURVE) else $error("stray transfer");
    AST_BUSY: assert property (s_start_idle |=> cal_busy_o) else $error("start lost");
    AST_DONE: assert property (cal_done_o |-> !cal_busy_o && $past(cal_busy_o))
        else $error("done outside window");
    // A low enable must hold the down current output and the window busy state
    AST_FROZEN: assert property (!$past(ce_i) && !$past(srst_i) |->
        $stable(pump_down_current_o) && $stable(cal_busy_o)) else $error("moved while disabled");
endmodule
bind plc_loop_regs plc_loop_regs_chk i_plc_loop_regs_chk (.*);
`default_nettype wire

// ### verif/plc_host_model.sv
/* Serial host model, reduced to the decoded word port.
   Assumes one clock shared with the register bank. */
`timescale 1ns/100ps
`default_nettype none
module plc_host_model (
    input  wire logic        clock_i,
    input  wire logic [23:0] rdata_i,
    input  wire logic        rvalid_i,
    output var  logic [4:0]  addr_o,
    output var  logic [23:0] wdata_o,
    output var  logic        wr_o,
    output var  logic        rd_o
);
    initial {addr_o, wdata_o, wr_o, rd_o} = '0;
    // Released lines show the inverse so stale values never look valid
    task automatic write(input logic [4:0] a, input logic [23:0] d);
        @(posedge clock_i) #1;
        {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
        @(posedge clock_i) #1;
        {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
    endtask
    task automatic read(input logic [4:0] a, output logic [23:0] d);
        @(posedge clock_i) #1;
        {addr_o, rd_o} = {a, 1'b1};
        @(posedge clock_i) #1;
        {addr_o, rd_o} = {~a, 1'b0};
        d = rvalid_i ? rdata_i : 24'hXXXXXX;
    endtask
    function automatic logic [23:0] pump_word(input logic frac, input logic [6:0] dn, up, mag);
        return {1'b0, frac, 1'b0, mag, up, dn};
    endfunction
    function automatic logic [23:0] cal_word(input logic [1:0] dv, input logic [2:0] w, input logic s);
        return (`PLC_RST_CAL & ~24'h007C07) | {9'h000, dv, {3{s}}, 7'h00, w};
    endfunction
    function automatic logic [23:0] det_word(input logic [10:0] f);
        return (`PLC_RST_DET & ~24'h0007F8) | f;
    endfunction
endmodule
`default_nettype wire

// ### verif/tb_plc_loop_regs.sv
/* Self-checking bench for the loop control register bank.
   Assumes the host model and checker compile before it. */
`timescale 1ns/100ps
`default_nettype none
`include "plc_regs.vh"
module tb_plc_loop_regs;
    logic clock_i = 0, srst_i = 1, ce_i = 1, uraw = 0, draw = 0, cst = 0;
    logic [8:0] pe = 0;
    logic [4:0] ad;
    logic [23:0] wd, rdat, got;
    logic wr, rd, rv, lu, ld, up, dn, slp, fc, sk, xf, tk, bsy, dne;
    logic [11:0] dc, uc;
    logic [9:0] lc;
    logic [2:0] dly;
    logic [31:0] seed = 32'h00012053;
    int mismatches = 0, num_checks = 0, mdl [3], n, nx = 0;
    logic [4:0] adr [3] = '{`PLC_ADDR_PUMP, `PLC_ADDR_CAL, `PLC_ADDR_DET};
    int win [8] = '{1, 2, 4, 8, 32, 64, 128, 256};
    int thr [4] = '{512, 54, 144, 241};
    int pes [6] = '{54, 55, 144, 145, 241, 242};
    int tks [4] = '{64, 16, 4, 2};
    plc_loop_regs i_plc_loop_regs (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i),
        .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .reg_rvalid_o(rv), .det_up_raw_i(uraw), .det_dn_raw_i(draw), .phase_err_i(pe),
        .cal_start_i(cst), .pump_down_current_o(dc), .pump_up_current_o(uc),
        .leak_current_o(lc), .leakage_up_on_o(lu), .leakage_down_on_o(ld),
        .detector_reset_delay_o(dly), .pump_up_o(up), .pump_down_o(dn), .slip_boost_o(slp),
        .use_forced_curve_o(fc), .skip_oscillator_cal_o(sk), .cal_transfer_start_o(xf),
        .cal_tick_o(tk), .cal_busy_o(bsy), .cal_done_o(dne));
    plc_host_model i_plc_host_model (.clock_i(clock_i), .rdata_i(rdat), .rvalid_i(rv),
        .addr_o(ad), .wdata_o(wd), .wr_o(wr), .rd_o(rd));
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clock_i);
        #1;
    endtask
    // Waits one more edge so the decoded outputs have caught up
    task automatic put(input int i, input logic [23:0] d);
        i_plc_host_model.write(adr[i], d);
        mdl[i] = d;
        cyc(1);
    endtask
    task automatic all_regs;
        for (int i = 0; i < 3; i++) begin
            i_plc_host_model.read(adr[i], got);
            chk("reg", got, mdl[i][23:0]);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    initial forever #5 clock_i = ~clock_i;
    always @(posedge clock_i) if (xf) nx++;
    initial begin
        #400000;
        mismatches++;
        tally_and_finish;
    end
    initial begin
        mdl = '{`PLC_RST_PUMP, `PLC_RST_CAL, `PLC_RST_DET};
        cyc(12);
        srst_i = 0;
        all_regs;
        chk("dly", dly, 1);
        i_plc_host_model.write(5'h1F, 24'hFFFFFF);
        i_plc_host_model.read(5'h1F, got);
        chk("unmapped", got, 0);
        repeat (6) begin
            seed = lfsr(seed);
            put(0, i_plc_host_model.pump_word(seed[0], seed[7:1], seed[14:8], seed[21:15]));
            chk("dcur", dc, seed[7:1] * 20);
            chk("ucur", uc, seed[14:8] * 20);
            chk("lcur", lc, seed[21:15] * 5);
            chk("leak", {ld, lu}, {seed[0], 1'b0});
            all_regs;
        end
        for (int i = 0; i < 8; i++) begin
            {uraw, draw} = {2{i[2]}};
            put(2, i_plc_host_model.det_word({i[0], i[1], 2'b00, i[1], i[0], 5'h00}));
            cyc(8);
            chk("up", up, (i[2] & i[0]) | i[1]);
            chk("dn", dn, (i[2] & i[1]) | i[0]);
        end
        for (int m = 0; m < 4; m++) begin
            put(2, i_plc_host_model.det_word({2'b00, m[1:0], 2'b11, 5'h00}));
            foreach (pes[k]) begin
                pe = pes[k][8:0];
                cyc(2);
                chk("slip", slp, m != 0 && pes[k] > thr[m]);
            end
        end
        for (int d = 0; d < 4; d++) begin
            put(1, i_plc_host_model.cal_word(d[1:0], 3'h0, 1'b0));
            cyc(40);
            n = 0;
            repeat (64) begin
                cyc(1);
                n += tk;
            end
            chk("ticks", n, tks[d]);
        end
        foreach (win[w]) begin
            put(1, i_plc_host_model.cal_word(2'b00, w[2:0], 1'b0));
            cst = 1;
            cyc(1);
            cst = 0;
            n = 0;
            while (bsy === 1'b1 && n < 600) begin
                n++;
                cyc(1);
            end
            chk("window", n, win[w]);
            chk("done", dne, 1);
        end
        for (int s = 0; s < 2; s++) begin
            put(1, i_plc_host_model.cal_word(2'b01, 3'h5, s[0]));
            chk("force", {fc, sk}, {2{s[0]}});
            n = nx;
            i_plc_host_model.write(`PLC_ADDR_CURVE, 24'h000000);
            cyc(2);
            chk("xfer", nx - n, s ^ 1);
        end
        // A write while disabled must not land, and outputs must hold
        ce_i = 0;
        i_plc_host_model.write(adr[0], i_plc_host_model.pump_word(1'b0, 7'h00, 7'h00, 7'h00));
        cyc(2);
        chk("frozen", dc, mdl[0][6:0] * 20);
        ce_i = 1;
        all_regs;
        srst_i = 1;
        cyc(2);
        srst_i = 0;
        mdl = '{`PLC_RST_PUMP, `PLC_RST_CAL, `PLC_RST_DET};
        all_regs;
        chk("dcur", dc, mdl[0][6:0] * 20);
        tally_and_finish;
    end
endmodule
`default_nettype wire
